// *** lasr_pkg.sv ***
package lasr_pkg;

  // four-bit indication codes sent toward the line card
  localparam logic [3:0] IND_WAKEUP_IN_PROGRESS = 4'h8;
  localparam logic [3:0] IND_DIGITAL_SUM_REACHED = 4'h7;
  localparam logic [3:0] IND_THROUGH_CONNECTED = 4'hc;
  localparam logic [3:0] IND_TEARDOWN_RUNNING = 4'h1;
  localparam logic [3:0] IND_TEARDOWN_DONE = 4'hf;
  localparam logic [3:0] IND_FRAME_REGAIN = 4'h4;
  localparam logic [3:0] IND_FEED_REMOVED = 4'h3;

  // four-bit command codes taken from the line card
  localparam logic [3:0] CMD_ACTIVATE = 4'h8;
  localparam logic [3:0] CMD_DEACTIVATE = 4'h0;
  localparam logic [3:0] CMD_LINE_TX_DISABLE = 4'h3;
  localparam logic [3:0] CMD_REINIT = 4'hd;

  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int COLD_START_MS = 1000;
  localparam int WARM_START_MS = 170;
  localparam int TEARDOWN_MS = 4;
  // longest times round down, least times round up
  localparam int COLD_START_CYC = COLD_START_MS * (1000000 / CLK_PERIOD_NS);
  localparam int WARM_START_CYC = WARM_START_MS * (1000000 / CLK_PERIOD_NS);
  localparam int TEARDOWN_CYC =
    (TEARDOWN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 24;

  // reset values
  localparam logic [3:0] STATUS_RST = 4'h0;

  typedef enum logic [6:0] {
    LASR_PDOWN = 7'h01,
    LASR_AWAKE = 7'h02,
    LASR_SYNC = 7'h04,
    LASR_THROUGH = 7'h08,
    LASR_REGAIN = 7'h10,
    LASR_TEARDOWN = 7'h20,
    LASR_TDONE = 7'h40
  } lasr_state_e;

endpackage

// *** lasr_frame_reporter.sv ***
`timescale 1ns/1ps
// holds one indication code per interface frame
module lasr_frame_reporter (
  input wire logic clk,
  input wire logic rst,
  input wire logic frame_start,
  input wire logic report_en,
  input wire logic [3:0] code_in,
  output logic [3:0] status_code_q,
  output logic status_valid_q
);
  import lasr_pkg::*;

  logic [3:0] status_code_d;
  logic status_valid_d;

  always_comb begin
    status_code_d = status_code_q;
    status_valid_d = status_valid_q;
    // codes only change on a frame boundary, repeated otherwise
    if (frame_start) begin // RULE15
      status_valid_d = report_en; // RULE8
      status_code_d = report_en ? code_in : STATUS_RST;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_code_q <= STATUS_RST;
      status_valid_q <= 1'b0;
    end else begin
      status_code_q <= status_code_d;
      status_valid_q <= status_valid_d;
    end
  end

endmodule

// *** lasr_top.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// RULE1: exchange side, powered and activating: indicate 1000.
// RULE2: receiver synchronized during activation: indicate 0111.
// RULE3: activation finished, channels transparent: indicate 1100.
// RULE4: deactivating after deactivate, reinit or line-disable: indicate 0001.
// RULE5: deactivation complete: indicate 1111.
// RULE6: frame alignment lost and being regained: indicate 0100.
// RULE7: power feed off high: indicate 0011 and send quiet line signal.
// RULE8: powered down: interface idle, no commands taken, no codes sent.
// RULE9: activation runs awake, then synchronize, then connect through.
// RULE10: activation within 1 s cold, 170 ms warm.
// RULE11: deactivation is line teardown then power down, about 4 ms.
// RULE12: controller sends 1000 to power up and activate.
// RULE13: controller sends 0000 to deactivate the line.
// RULE14: 0011 stops transmission and powers down; 1101 reinitialises.
// RULE15: code repeats every frame, changes only on a frame boundary.
module lasr_top #(
  parameter int COLD_CYC = lasr_pkg::COLD_START_CYC,
  parameter int WARM_CYC = lasr_pkg::WARM_START_CYC,
  parameter int TEARDOWN_CYC_P = lasr_pkg::TEARDOWN_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic exchange_side_mode,
  input wire logic frame_start,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic power_feed_off_input,
  input wire logic rx_synced,
  input wire logic far_end_synced,
  input wire logic rx_frame_lost,
  output logic [3:0] status_code_q,
  output logic status_valid_q,
  output logic if_active_q,
  output logic line_tx_en_q,
  output logic quiet_line_signal_q,
  output logic through_connected_q,
  output logic act_timeout_q
);
  import lasr_pkg::*;

  if (COLD_CYC < 1 || WARM_CYC < 1 || TEARDOWN_CYC_P < 1 ||
      COLD_CYC >= (1 << TIMER_W) || WARM_CYC >= (1 << TIMER_W) ||
      TEARDOWN_CYC_P >= (1 << TIMER_W) || WARM_CYC > COLD_CYC) begin : g_bad_timing
    $error("lasr_top: timing parameter out of range");
  end

  localparam logic [TIMER_W-1:0] COLD_LIM = TIMER_W'(COLD_CYC);
  localparam logic [TIMER_W-1:0] WARM_LIM = TIMER_W'(WARM_CYC);
  localparam logic [TIMER_W-1:0] TD_LIM = TIMER_W'(TEARDOWN_CYC_P);

  function automatic logic is_cmd(input logic v, input logic [3:0] c,
                                  input logic [3:0] want);
    is_cmd = v && (c == want);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  lasr_state_e state_q, state_d;
  logic [TIMER_W-1:0] timer_q, timer_d;
  logic warm_q, warm_d;
  logic reinit_q, reinit_d;
  logic if_active_d, line_tx_en_d, quiet_d, through_d, timeout_d;
  logic [3:0] code_d;
  logic code_en;
  logic take_cmd, go_teardown;
  logic [TIMER_W-1:0] act_lim;

  // commands only count while the interface is up
  assign take_cmd = cmd_valid && exchange_side_mode &&
                    (state_q != LASR_PDOWN); // RULE8
  assign go_teardown = is_cmd(take_cmd, cmd_code, CMD_DEACTIVATE) || // RULE13
                       is_cmd(take_cmd, cmd_code, CMD_LINE_TX_DISABLE) ||
                       is_cmd(take_cmd, cmd_code, CMD_REINIT); // RULE14
  // coefficients survive power down, so a start after one that reached through-connection is warm unless reinit cleared them
  assign act_lim = warm_q ? WARM_LIM : COLD_LIM; // RULE10

  always_comb begin
    state_d = state_q;
    timer_d = timer_q + TIMER_W'(1);
    warm_d = warm_q;
    reinit_d = reinit_q;
    timeout_d = act_timeout_q;
    unique case (state_q)
      LASR_PDOWN: begin
        timer_d = '0;
        // the activate code is the one wake-up that power down hears
        if (cmd_valid && exchange_side_mode &&
            cmd_code == CMD_ACTIVATE) begin // RULE12
          state_d = LASR_AWAKE;
          timeout_d = 1'b0;
        end
      end
      LASR_AWAKE: begin
        if (rx_synced) begin
          state_d = LASR_SYNC; // RULE9
        end
      end
      LASR_SYNC: begin
        if (far_end_synced && rx_synced) begin
          state_d = LASR_THROUGH; // RULE9
          warm_d = 1'b1;
        end else if (!rx_synced) begin
          state_d = LASR_AWAKE;
        end
      end
      LASR_THROUGH: begin
        timer_d = '0;
        if (rx_frame_lost) begin
          state_d = LASR_REGAIN; // RULE6
        end
      end
      LASR_REGAIN: begin
        timer_d = '0;
        if (!rx_frame_lost) begin
          state_d = LASR_THROUGH;
        end
      end
      LASR_TEARDOWN: begin
        if (timer_q >= TD_LIM - TIMER_W'(1)) begin
          state_d = LASR_TDONE; // RULE11
          timer_d = '0;
        end
      end
      LASR_TDONE: begin
        timer_d = '0;
        // leave once the current report has stood a whole frame;
        // feed-off or a dropped mode must not trap us here
        if (frame_start && (!code_en ||
            (status_valid_q && status_code_q == code_d))) begin
          state_d = LASR_PDOWN; // RULE11
          if (reinit_q) begin
            warm_d = 1'b0; // RULE14
          end
          reinit_d = 1'b0;
        end
      end
    endcase
    // activation that overruns its limit is abandoned
    if ((state_q == LASR_AWAKE || state_q == LASR_SYNC) &&
        timer_q >= act_lim - TIMER_W'(1)) begin // RULE10
      state_d = LASR_TEARDOWN;
      timer_d = '0;
      timeout_d = 1'b1;
    end
    if (go_teardown && state_q != LASR_TEARDOWN &&
        state_q != LASR_TDONE) begin
      state_d = LASR_TEARDOWN; // RULE4
      timer_d = '0;
    end
    if (is_cmd(take_cmd, cmd_code, CMD_REINIT)) begin
      reinit_d = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= LASR_PDOWN;
      timer_q <= '0;
      warm_q <= 1'b0;
      reinit_q <= 1'b0;
      act_timeout_q <= 1'b0;
    end else begin
      state_q <= state_d;
      timer_q <= timer_d;
      warm_q <= warm_d;
      reinit_q <= reinit_d;
      act_timeout_q <= timeout_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // indication encoder and line-side controls
  always_comb begin
    code_d = IND_TEARDOWN_DONE;
    code_en = 1'b1;
    unique case (state_q)
      LASR_PDOWN: code_en = 1'b0; // RULE8
      LASR_AWAKE: code_d = IND_WAKEUP_IN_PROGRESS; // RULE1
      LASR_SYNC: code_d = IND_DIGITAL_SUM_REACHED; // RULE2
      LASR_THROUGH: code_d = IND_THROUGH_CONNECTED; // RULE3
      LASR_REGAIN: code_d = IND_FRAME_REGAIN; // RULE6
      LASR_TEARDOWN: code_d = IND_TEARDOWN_RUNNING; // RULE4
      LASR_TDONE: code_d = IND_TEARDOWN_DONE; // RULE5
    endcase
    // feed removal outranks every other report
    if (power_feed_off_input && exchange_side_mode &&
        state_q != LASR_PDOWN) begin
      code_d = IND_FEED_REMOVED; // RULE7
    end
    if (!exchange_side_mode) begin
      code_en = 1'b0;
    end
    if_active_d = (state_q != LASR_PDOWN) && exchange_side_mode; // RULE8
    quiet_d = power_feed_off_input && exchange_side_mode; // RULE7
    line_tx_en_d = !quiet_d && exchange_side_mode &&
                   (state_q == LASR_AWAKE || state_q == LASR_SYNC ||
                    state_q == LASR_THROUGH || state_q == LASR_REGAIN);
    through_d = (state_q == LASR_THROUGH) && !quiet_d; // RULE3
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      if_active_q <= 1'b0;
      line_tx_en_q <= 1'b0;
      quiet_line_signal_q <= 1'b0;
      through_connected_q <= 1'b0;
    end else begin
      if_active_q <= if_active_d;
      line_tx_en_q <= line_tx_en_d;
      quiet_line_signal_q <= quiet_d;
      through_connected_q <= through_d;
    end
  end

  lasr_frame_reporter u_reporter (
    .clk(clk),
    .rst(rst),
    .frame_start(frame_start),
    .report_en(code_en),
    .code_in(code_d),
    .status_code_q(status_code_q),
    .status_valid_q(status_valid_q)
  );

endmodule

// *** lasr_ast_checker.sv ***
`timescale 1ns/1ps
module lasr_ast_checker import lasr_pkg::*; #(
  parameter int COLD_CYC = 300
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic exchange_side_mode,
  input wire logic frame_start,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic power_feed_off_input,
  input wire logic rx_synced,
  input wire logic far_end_synced,
  input wire logic [3:0] status_code_q,
  input wire logic status_valid_q,
  input wire logic if_active_q,
  input wire logic line_tx_en_q,
  input wire logic quiet_line_signal_q,
  input wire logic through_connected_q,
  input wire logic act_timeout_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // cycles spent activating or regaining frame alignment; slack covers the output lag
  int act_d, act_q;
  always_comb begin
    act_d = (line_tx_en_q && !through_connected_q) ? act_q + 1 : 0;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) act_q <= 0;
    else act_q <= act_d;
  end
  ////////////////////////////////////////////////////////////////////////////
  AST_WAKE: assert property (cmd_valid && exchange_side_mode &&
    cmd_code == CMD_ACTIVATE && !if_active_q && !line_tx_en_q
    |-> ##2 if_active_q) else $error("activate did not power up");
  AST_FRAME_HOLD: assert property (!$past(frame_start) |->
    $stable(status_code_q) && $stable(status_valid_q))
    else $error("code changed inside a frame");
  AST_PDOWN_QUIET: assert property (frame_start && !if_active_q &&
    !$past(if_active_q) && $past(exchange_side_mode) && !$past(cmd_valid)
    |=> !status_valid_q)
    else $error("code sent in power down");
  AST_FEED_CODE: assert property (frame_start &&
    power_feed_off_input && $past(power_feed_off_input) &&
    if_active_q && $past(if_active_q) |=> status_code_q == IND_FEED_REMOVED)
    else $error("feed off code missing");
  AST_FEED_QUIET: assert property (power_feed_off_input &&
    if_active_q |-> ##[1:2] quiet_line_signal_q)
    else $error("quiet line not sent");
  AST_FEED_TX_OFF: assert property (quiet_line_signal_q &&
    $past(quiet_line_signal_q) |-> !line_tx_en_q && !through_connected_q)
    else $error("line active while feed off");
  AST_THROUGH_ORDER: assert property ($rose(through_connected_q)
    |-> $past(rx_synced, 2) && $past(far_end_synced, 2))
    else $error("connected before sync");
  AST_ACT_LIMIT: assert property (act_q <= COLD_CYC + 8)
    else $error("activation overran");
  AST_TEARDOWN_CODE: assert property (cmd_valid &&
    exchange_side_mode && cmd_code == CMD_DEACTIVATE && through_connected_q
    && !power_feed_off_input
    |-> ##[2:15] status_code_q == IND_TEARDOWN_RUNNING)
    else $error("teardown code missing");
  COV_THROUGH: cover property ($rose(through_connected_q));
  COV_FEED: cover property ($rose(quiet_line_signal_q));
  COV_TIMEOUT: cover property ($rose(act_timeout_q));
endmodule

// *** lasr_card_model.sv ***
`timescale 1ns/1ps
module lasr_card_model (
  input wire logic clk,
  input wire logic rst,
  output logic frame_start,
  output logic cmd_valid,
  output logic [3:0] cmd_code
);
  // short frame keeps the run brief; ten cycles apart
  int cnt;
  initial begin
    cnt = 0;
    frame_start = 0;
    cmd_valid = 0;
    cmd_code = 4'h0;
  end
  always @(posedge clk) begin
    cnt <= (cnt == 9) ? 0 : cnt + 1;
    frame_start <= (cnt == 9);
  end
  // released code is inverted so a stale value never looks valid
  task automatic send(input logic [3:0] c);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_code <= ~c;
  endtask
endmodule

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
  import lasr_pkg::*;
  localparam int COLD = 300;
  localparam int WARM = 150;
  logic clk, rst, esm, fs, cv, pfo, rxs, fes, rfl;
  logic [3:0] cc, sc;
  logic sv, ia, lte, qls, tc, ato;
  int mismatches, total_checks, n;
  lasr_card_model u_card (.clk(clk), .rst(rst), .frame_start(fs),
    .cmd_valid(cv), .cmd_code(cc));
  lasr_top #(.COLD_CYC(COLD), .WARM_CYC(WARM), .TEARDOWN_CYC_P(20)) u_dut (
    .clk(clk), .rst(rst), .exchange_side_mode(esm), .frame_start(fs),
    .cmd_valid(cv), .cmd_code(cc), .power_feed_off_input(pfo),
    .rx_synced(rxs), .far_end_synced(fes), .rx_frame_lost(rfl),
    .status_code_q(sc), .status_valid_q(sv), .if_active_q(ia),
    .line_tx_en_q(lte), .quiet_line_signal_q(qls),
    .through_connected_q(tc), .act_timeout_q(ato));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [3:0] g, input logic [3:0] e);
    total_checks++;
    if (g !== e) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      mismatches++;
    end
  endtask
  task automatic frames(input int k);
    repeat (k) begin
      @(posedge clk);
      while (fs !== 1'b1) @(posedge clk);
    end
    @(posedge clk);
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic t_refused();
    u_card.send(CMD_DEACTIVATE);
    u_card.send(CMD_ACTIVATE);
    frames(3);
    chk(ia, 1'b0);
    chk(sv, 1'b0);
  endtask
  task automatic t_act();
    @(posedge clk);
    esm <= 1'b1;
    rxs <= 1'b0;
    fes <= 1'b0;
    u_card.send(CMD_ACTIVATE);
    frames(3);
    chk(sc, IND_WAKEUP_IN_PROGRESS);
    chk(sv, 1'b1);
    chk(lte, 1'b1);
    chk(ato, 1'b0);
    rxs <= 1'b1;
    frames(3);
    chk(sc, IND_DIGITAL_SUM_REACHED);
    fes <= 1'b1;
    frames(3);
    chk(sc, IND_THROUGH_CONNECTED);
    chk(tc, 1'b1);
  endtask
  task automatic t_regain_feed();
    rfl <= 1'b1;
    frames(3);
    chk(sc, IND_FRAME_REGAIN);
    rfl <= 1'b0;
    frames(3);
    chk(sc, IND_THROUGH_CONNECTED);
    pfo <= 1'b1;
    frames(3);
    chk(sc, IND_FEED_REMOVED);
    chk(qls, 1'b1);
    chk(lte, 1'b0);
    pfo <= 1'b0;
    frames(3);
    chk(qls, 1'b0);
    chk(sc, IND_THROUGH_CONNECTED);
  endtask
  task automatic t_deact(input logic [3:0] c);
    u_card.send(c);
    frames(2);
    chk(sc, IND_TEARDOWN_RUNNING);
    n = 0;
    while (sc !== IND_TEARDOWN_DONE && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk(sc, IND_TEARDOWN_DONE);
    frames(3);
    chk(sv, 1'b0);
    chk(ia, 1'b0);
    chk(lte, 1'b0);
  endtask
  task automatic t_timeout(input int lim);
    rxs <= 1'b0;
    fes <= 1'b0;
    u_card.send(CMD_ACTIVATE);
    n = 0;
    while (ato !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk(n > lim && n <= lim + 10, 1'b1);
    // abandoned activation must still tear down to power down
    frames(5);
    chk(ia, 1'b0);
    chk(sv, 1'b0);
  endtask
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  // generous span: whole run needs about 1,250 cycles
  initial begin
    #2000000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    mismatches = 0;
    total_checks = 0;
    rst = 1;
    {esm, pfo, rxs, fes, rfl} = 5'h00;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_refused();
    t_act();
    t_regain_feed();
    t_deact(CMD_DEACTIVATE);
    t_act();
    t_deact(CMD_LINE_TX_DISABLE);
    t_timeout(WARM);
    t_act();
    t_deact(CMD_REINIT);
    t_timeout(COLD);
    tally_and_finish();
  end
endmodule
bind lasr_top lasr_ast_checker #(.COLD_CYC(COLD_CYC)) u_chk (.clk(clk),
  .rst(rst), .exchange_side_mode(exchange_side_mode),
  .frame_start(frame_start), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
  .power_feed_off_input(power_feed_off_input), .rx_synced(rx_synced),
  .far_end_synced(far_end_synced), .status_code_q(status_code_q),
  .status_valid_q(status_valid_q), .if_active_q(if_active_q),
  .line_tx_en_q(line_tx_en_q), .quiet_line_signal_q(quiet_line_signal_q),
  .through_connected_q(through_connected_q), .act_timeout_q(act_timeout_q));
